/* gsp_global_protect.sv */
//
// Overview of operation
// - Allowed write with bits 5..2 all ones protects every sector.
// - Allowed write with bits 5..2 all zeros unprotects every sector.
// - Any other pattern in bits 5..2 leaves sector bits unchanged.
// - Lock clear, writing 00h unprotects all, lock stays clear.
// - Lock clear, writing 7Fh protects all, lock stays clear.
// - Lock clear, writing FFh protects all and sets lock.
// - Writing 0Fh with protect pin high clears lock, no global change.
// - Writing F0h with lock clear sets lock, sectors untouched.
// - Bits 5..2 are decoded only, never stored.
// - Only bit 7 is stored as lock when a change is allowed.
// - Status bits 4..2 show pin state and aggregate protection.
// - Pin low and lock set: no global op, lock unchanged.
// - Pin high and lock set: no global protection change.
// - Pin high and lock set: bit 7 zero clears lock.
// - Per-sector commands still change single bits after global op.
// - Status write executes only with write enable latch set.
`timescale 1ns/1ps
`include "gsp_consts.svh"

module gsp_global_protect
    import gsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    input wire logic wp_b,
    input wire logic wrsr_sel,
    input wire logic write_enable_latch,
    input wire logic sect_cmd_valid,
    input wire logic sect_cmd_set,
    input wire logic [3:0] sect_cmd_idx,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic sector_prot_lock,
    output logic [15:0] sector_prot,
    output logic [7:0] status_bits,
    output logic wel_clr
);

    // ==========================================================
    // Pin synchronisers and byte capture
    logic [3:0] pins_s;
    logic cs_b_s;
    logic sck_s;
    logic si_s;
    logic wp_b_s;
    logic [7:0] data_byte;
    logic frame_full;
    logic frame_end;

    gsp_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in({wp_b, si, sck, cs_b}),
        .pin_out(pins_s)
    );

    assign cs_b_s = pins_s[0];
    assign sck_s = pins_s[1];
    assign si_s = pins_s[2];
    assign wp_b_s = pins_s[3];

    gsp_byte_rx u_rx (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .cs_b_s(cs_b_s),
        .sck_s(sck_s),
        .si_s(si_s),
        .data_byte(data_byte),
        .frame_full(frame_full),
        .frame_end(frame_end)
    );

    // ==========================================================
    // Decode
    gsp_st_t st_r;
    gsp_st_t st_nxt;

    logic [3:0] dec_field;
    logic dec_all_one;
    logic dec_all_zero;
    logic hw_locked;
    logic wr_exec;
    logic [1:0] swp;
    logic [7:0] stat_byte;

    // Field is only looked at here, no flop keeps it
    assign dec_field = data_byte[`GSP_DEC_HI:`GSP_DEC_LO];
    assign dec_all_one = &dec_field;
    assign dec_all_zero = ~|dec_field;
    assign hw_locked = !wp_b_s && st_r.lock;

    // Whole data byte then chip select rise, with latch set
    assign wr_exec = frame_end && frame_full && wrsr_sel
                     && write_enable_latch;

    always_comb begin
        if (&st_r.sect) begin
            swp = `GSP_SWP_ALL;
        end else if (|st_r.sect) begin
            swp = `GSP_SWP_SOME;
        end else begin
            swp = `GSP_SWP_NONE;
        end
    end

    // Bits 4..2 report pin and aggregate state, not the written data
    always_comb begin
        stat_byte = 8'h0;
        stat_byte[`GSP_BIT_LOCK] = st_r.lock;
        stat_byte[`GSP_BIT_WP] = wp_b_s;
        stat_byte[`GSP_SWP_HI:`GSP_SWP_LO] = swp;
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.wel_clr = 1'b0;

        // Per-sector commands work while unlocked; a global change in the same cycle wins
        if (sect_cmd_valid && !st_r.lock) begin
            st_nxt.sect[sect_cmd_idx] = sect_cmd_set;
        end

        if (wr_exec) begin
            st_nxt.wel_clr = 1'b1;
            // Global decode only while unlocked; a soft-locked part
            // needs one write to unlock and a second to act
            if (!st_r.lock && st_r.glob_en) begin
                if (dec_all_one) begin
                    st_nxt.sect = `GSP_SECT_RST;
                end else if (dec_all_zero) begin
                    st_nxt.sect = 16'h0;
                end
                // Other patterns fall through untouched
            end
            // Hard lock freezes the bit; otherwise bit 7 is stored
            if (!hw_locked) begin
                st_nxt.lock = data_byte[`GSP_BIT_LOCK];
            end
        end

        if (reg_wr && reg_addr == `GSP_OFS_CTRL) begin
            st_nxt.glob_en = reg_wdata[0];
        end

        st_nxt.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `GSP_OFS_STATUS: st_nxt.rdata = {24'h0, stat_byte};
                `GSP_OFS_SECT: st_nxt.rdata = {16'h0, st_r.sect};
                `GSP_OFS_CTRL: st_nxt.rdata = {31'h0, st_r.glob_en};
                default: st_nxt.rdata = 32'h0;
            endcase
        end
    end

    // Power-up state: all sectors protected, lock clear
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{lock: `GSP_LOCK_RST, sect: `GSP_SECT_RST,
                      glob_en: `GSP_CTRL_RST, rdata: 32'h0,
                      wel_clr: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign sector_prot_lock = st_r.lock;
    assign sector_prot = st_r.sect;
    assign status_bits = stat_byte;
    assign wel_clr = st_r.wel_clr;

endmodule : gsp_global_protect

/* gsp_consts.svh */
`ifndef GSP_CONSTS_SVH
`define GSP_CONSTS_SVH

// ==========================================================
// Register port offsets
`define GSP_OFS_STATUS 4'h0
`define GSP_OFS_SECT 4'h4
`define GSP_OFS_CTRL 4'h8

// ==========================================================
// Status byte fields
`define GSP_BIT_LOCK 7
`define GSP_BIT_WP 4
`define GSP_DEC_HI 5
`define GSP_DEC_LO 2
`define GSP_SWP_HI 3
`define GSP_SWP_LO 2

// ==========================================================
// Reset values and counts
`define GSP_LOCK_RST 1'h0
`define GSP_SECT_RST 16'hffff
`define GSP_CTRL_RST 1'h1
`define GSP_FRAME_BITS 5'h10
`define GSP_SWP_NONE 2'h0
`define GSP_SWP_SOME 2'h1
`define GSP_SWP_ALL 2'h3

`endif

/* gsp_pkg.sv */
package gsp_pkg;

    typedef struct packed {
        logic [3:0] q1;
        logic [3:0] q2;
        logic [3:0] q3;
        logic [3:0] o;
    } gsp_sync_t;

    typedef struct packed {
        logic [7:0] sh;
        logic [4:0] cnt;
        logic [7:0] data;
        logic sck_d;
        logic cs_d;
        logic end_p;
        logic full;
    } gsp_rx_t;

    typedef struct packed {
        logic lock;
        logic [15:0] sect;
        logic glob_en;
        logic [31:0] rdata;
        logic wel_clr;
    } gsp_st_t;

endpackage : gsp_pkg

/* gsp_pin_sync.sv */
`timescale 1ns/1ps
`include "gsp_consts.svh"

module gsp_pin_sync
    import gsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_out
);

    gsp_sync_t st_r;
    gsp_sync_t st_nxt;

    // ==========================================================
    // Three stages; a change is taken once stages two and three agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.q1 = pin_in;
        st_nxt.q2 = st_r.q1;
        st_nxt.q3 = st_r.q2;
        for (int i = 0; i < 4; i++) begin
            if (st_r.q2[i] == st_r.q3[i]) begin
                st_nxt.o[i] = st_r.q3[i];
            end
        end
    end

    // Idle levels: chip select and write protect high, clock low
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{q1: 4'h9, q2: 4'h9, q3: 4'h9, o: 4'h9};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.o;

endmodule : gsp_pin_sync

/* gsp_byte_rx.sv */
`timescale 1ns/1ps
`include "gsp_consts.svh"

module gsp_byte_rx
    import gsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cs_b_s,
    input wire logic sck_s,
    input wire logic si_s,
    output logic [7:0] data_byte,
    output logic frame_full,
    output logic frame_end
);

    gsp_rx_t st_r;
    gsp_rx_t st_nxt;

    // ==========================================================
    // Shift on SCK rise (modes 0 and 3); second byte is the data
    always_comb begin
        st_nxt = st_r;
        st_nxt.sck_d = sck_s;
        st_nxt.cs_d = cs_b_s;
        st_nxt.end_p = cs_b_s && !st_r.cs_d;
        // Full must outlive the end pulse so the decode sees both at once
        if (st_r.end_p) begin
            st_nxt.full = 1'b0;
        end
        if (cs_b_s) begin
            if (!st_r.cs_d) begin
                st_nxt.cnt = 5'h0;
            end
        end else if (sck_s && !st_r.sck_d) begin
            st_nxt.sh = {st_r.sh[6:0], si_s};
            // Count saturates so trailing bytes are ignored
            if (st_r.cnt != `GSP_FRAME_BITS) begin
                st_nxt.cnt = st_r.cnt + 5'h1;
            end
            if (st_r.cnt == `GSP_FRAME_BITS - 5'h1) begin
                st_nxt.data = {st_r.sh[6:0], si_s};
                st_nxt.full = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{sh: 8'h0, cnt: 5'h0, data: 8'h0, sck_d: 1'b0,
                      cs_d: 1'b1, end_p: 1'b0, full: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data_byte = st_r.data;
    assign frame_full = st_r.full;
    assign frame_end = st_r.end_p;

endmodule : gsp_byte_rx

/* gsp_chk_assertions.sv */
`timescale 1ns/1ps

module gsp_chk
    import gsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic write_enable_latch,
    input wire logic sect_cmd_valid,
    input wire logic sect_cmd_set,
    input wire logic [3:0] sect_cmd_idx,
    input wire logic sector_prot_lock,
    input wire logic [15:0] sector_prot,
    input wire logic [7:0] status_bits,
    input wire logic wel_clr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Locking
    hard_lock_a: assert property (!status_bits[4] && sector_prot_lock
        |=> sector_prot_lock) else $error("hard lock moved");
    soft_lock_a: assert property (sector_prot_lock
        |=> $stable(sector_prot)) else $error("locked sectors moved");
    lock_write_a: assert property ($changed(sector_prot_lock)
        |-> wel_clr) else $error("lock moved outside a write");

    // ==========================================================
    // Sector bits and status
    global_all_a: assert property (
        $changed(sector_prot) && !$past(sect_cmd_valid)
        |-> wel_clr && sector_prot inside {16'h0000, 16'hffff})
        else $error("partial global change");
    sect_cmd_a: assert property (
        sect_cmd_valid && !sector_prot_lock |=> wel_clr ||
        sector_prot[$past(sect_cmd_idx)] == $past(sect_cmd_set))
        else $error("sector command lost");
    swp_sum_a: assert property (status_bits[7] == sector_prot_lock &&
        status_bits[3:2] == (sector_prot == 16'hffff ? 2'h3 :
        sector_prot == 16'h0000 ? 2'h0 : 2'h1))
        else $error("status summary wrong");
    no_store_a: assert property (status_bits[6:5] == 2'h0 &&
        status_bits[1:0] == 2'h0) else $error("written bits stored");
    wel_pulse_a: assert property (wel_clr
        |-> $past(write_enable_latch) ##1 !wel_clr)
        else $error("bad completion pulse");
endmodule : gsp_chk

bind gsp_global_protect gsp_chk u_gsp_chk (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .write_enable_latch(write_enable_latch),
    .sect_cmd_valid(sect_cmd_valid),
    .sect_cmd_set(sect_cmd_set),
    .sect_cmd_idx(sect_cmd_idx),
    .sector_prot_lock(sector_prot_lock),
    .sector_prot(sector_prot),
    .status_bits(status_bits),
    .wel_clr(wel_clr)
);

/* gsp_host_model.sv */
`timescale 1ns/1ps

module gsp_host_model (
    input wire logic sys_clk,
    output logic cs_b,
    output logic sck,
    output logic si
);
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // Step of 4 cycles; SCK high one step, low two, keeps the synchronised sampling safe
    task automatic step();
        repeat (4) @(posedge sys_clk);
    endtask : step

    // Mode 0, MSB first; the clock stands low outside frames
    task automatic send(input logic [15:0] w, input int n);
        cs_b <= 1'b0;
        for (int i = 0; i < n; i++) begin
            step();
            si <= w[15 - i];
            step();
            sck <= 1'b1;
            step();
            sck <= 1'b0;
        end
        step();
        cs_b <= 1'b1;
        // Released data line must not keep showing the last bit
        si <= ~si;
        repeat (16) @(posedge sys_clk);
    endtask : send
endmodule : gsp_host_model

/* gsp_global_protect_tb.sv */
`timescale 1ns/1ps

module gsp_global_protect_tb
    import gsp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic wp_b = 1'b1;
    logic wrsr_sel = 1'b1;
    logic write_enable_latch = 1'b1;
    logic sect_cmd_valid = 1'b0;
    logic sect_cmd_set = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] sect_cmd_idx = 4'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic cs_b, sck, si, sector_prot_lock, wel_clr;
    logic [15:0] sector_prot;
    logic [7:0] status_bits;
    int err_count = 0;
    int tests_run = 0;
    int pulses = 0;

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (wel_clr === 1'b1) pulses <= pulses + 1;

    gsp_global_protect u_gsp_global_protect (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .cs_b(cs_b),
        .sck(sck),
        .si(si),
        .wp_b(wp_b),
        .wrsr_sel(wrsr_sel),
        .write_enable_latch(write_enable_latch),
        .sect_cmd_valid(sect_cmd_valid),
        .sect_cmd_set(sect_cmd_set),
        .sect_cmd_idx(sect_cmd_idx),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .sector_prot_lock(sector_prot_lock),
        .sector_prot(sector_prot),
        .status_bits(status_bits),
        .wel_clr(wel_clr)
    );

    gsp_host_model u_gsp_host_model (
        .sys_clk(sys_clk),
        .cs_b(cs_b),
        .sck(sck),
        .si(si)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // Pulse count below zero: completion pulse not judged
    task automatic wsr(input logic [7:0] d, input logic [15:0] s,
                       input logic l, input int p, input int n = 16);
        int p0;
        p0 = pulses;
        u_gsp_host_model.send({8'h01, d}, n);
        chk("sector_prot", {16'h0, s}, {16'h0, sector_prot});
        chk("lock", {31'h0, l}, {31'h0, sector_prot_lock});
        if (p >= 0) chk("wel_clr", p, pulses - p0);
    endtask : wsr

    task automatic sect(input logic [3:0] i, input logic s,
                        input logic [15:0] e);
        sect_cmd_idx <= i;
        sect_cmd_set <= s;
        sect_cmd_valid <= 1'b1;
        @(posedge sys_clk);
        sect_cmd_valid <= 1'b0;
        #1 chk("sect_cmd", {16'h0, e}, {16'h0, sector_prot});
        @(posedge sys_clk);
    endtask : sect

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
        @(posedge sys_clk);
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic pin(input logic v);
        wp_b <= v;
        repeat (8) @(posedge sys_clk);
    endtask : pin

    // ==========================================================
    // Scenarios
    task automatic t_global();
        wsr(8'h00, 16'h0000, 1'b0, 1);
        wsr(8'h14, 16'h0000, 1'b0, 1);
        wsr(8'h7f, 16'hffff, 1'b0, 1);
        rd(4'h0, 32'h1c);
    endtask : t_global

    task automatic t_lock();
        wsr(8'hff, 16'hffff, 1'b1, 1);
        wsr(8'h00, 16'hffff, 1'b0, 1);
        wsr(8'h00, 16'h0000, 1'b0, 1);
        wsr(8'hf0, 16'h0000, 1'b1, 1);
        rd(4'h0, 32'h90);
        sect(4'h3, 1'b1, 16'h0000);
        wsr(8'h0f, 16'h0000, 1'b0, 1);
    endtask : t_lock

    task automatic t_hard();
        wsr(8'hf0, 16'h0000, 1'b1, 1);
        pin(1'b0);
        wsr(8'h0f, 16'h0000, 1'b1, -1);
        wsr(8'h7f, 16'h0000, 1'b1, -1);
        rd(4'h0, 32'h80);
        pin(1'b1);
        wsr(8'h0f, 16'h0000, 1'b0, 1);
    endtask : t_hard

    task automatic t_refuse();
        write_enable_latch <= 1'b0;
        wsr(8'h7f, 16'h0000, 1'b0, 0);
        write_enable_latch <= 1'b1;
        wsr(8'h7f, 16'h0000, 1'b0, 0, 12);
        // Frame not flagged as a status write by the opcode decoder
        wrsr_sel <= 1'b0;
        wsr(8'h7f, 16'h0000, 1'b0, 0);
        wrsr_sel <= 1'b1;
    endtask : t_refuse

    task automatic t_sector();
        sect(4'h3, 1'b1, 16'h0008);
        wsr(8'h7f, 16'hffff, 1'b0, 1);
        sect(4'h0, 1'b0, 16'hfffe);
        rd(4'h4, 32'hfffe);
        wr(4'hc, 32'hff);
        rd(4'hc, 32'h0);
        rd(4'h0, 32'h14);
        // Global decode switched off: lock still stored, sectors kept
        rd(4'h8, 32'h1);
        wr(4'h8, 32'h0);
        rd(4'h8, 32'h0);
        wsr(8'h80, 16'hfffe, 1'b1, 1);
        wsr(8'h00, 16'hfffe, 1'b0, 1);
        wr(4'h8, 32'h1);
        rd(4'h8, 32'h1);
    endtask : t_sector

    task automatic summarize();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_global();
        t_lock();
        t_hard();
        t_refuse();
        t_sector();
        summarize();
    end

    // About 18 frames of some 212 cycles each; ample margin
    initial begin
        #100000;
        err_count++;
        summarize();
    end
endmodule : gsp_global_protect_tb
